// ===== rtl/fault_consts.svh
/*
  Register offsets, field positions, reset values, fault code words and
  timing figures of the controller fault manager.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH

// Register byte offsets on the 12-bit APB address.
`define OFS_STATUS 12'h000
`define OFS_FLAGS  12'h004
`define OFS_BCODE  12'h008
`define OFS_PCODE  12'h00C
`define OFS_CTRL   12'h010
`define OFS_CMD    12'h014

// Flag positions within the flags register.
`define FLG_STRING 0
`define FLG_ARITH  1
`define FLG_INDEX  2
`define FLG_WDOG   3
`define FLG_CHART  4

// Control register fields and reset value.
`define CTL_DIAG      0
`define CTL_AUTORUN   1
`define CTL_ESC_LSB   2
`define CTL_RESET     7'h00

// Command register bits.
`define CMD_RUN    0
`define CMD_STOP   1
`define CMD_REINIT 2

// Blocking fault code words.
`define BC_WATCHDOG    16'hDEB0
`define BC_CHART_TABLE 16'hDEF7
`define BC_CHART_STEP  16'hDEFE
`define BC_HALT_INSTR  16'h2258
`define BC_JUMP        16'hDEF8
`define BC_STRING      16'hDEF1
`define BC_DIV0        16'hDEF0
`define BC_CAPOV       16'hDEF2
`define BC_FLOAT       16'hDE87
`define BC_INDEX       16'hDEF3

// Processor fault code words.
`define PC_SYS_WD_BUS  8'h80
`define PC_BUS_WIRING  8'h81
`define PC_CODE        8'h01
`define PC_IRQ         8'h02
`define PC_SYS_STACK   8'h03
`define PC_USER_STACK  8'h04

// Lamp blink half period and clock rate.
`define BLINK_HALF_MS  250
`define PCLK_MHZ       100

`endif

// ===== rtl/fault_pkg.sv
/*
  Types shared by the controller fault manager modules.
  Assumes nothing of its surroundings.
*/
package fault_pkg;

  typedef enum logic [2:0] {
    ST_STOPPED = 3'b000,
    ST_RUNNING = 3'b001,
    ST_HALT    = 3'b010,
    ST_ERROR   = 3'b011
  } state_type;

  typedef enum logic [2:0] {
    EK_STRING = 3'b000,
    EK_DIV0   = 3'b001,
    EK_CAPOV  = 3'b010,
    EK_FLOAT  = 3'b011,
    EK_INDEX  = 3'b100
  } exec_kind_type;

  typedef enum logic [2:0] {
    BK_WATCHDOG    = 3'b000,
    BK_CHART_TABLE = 3'b001,
    BK_CHART_STEP  = 3'b010,
    BK_HALT_INSTR  = 3'b011,
    BK_JUMP        = 3'b100
  } block_kind_type;

  typedef enum logic [2:0] {
    PK_SYS_WD_BUS = 3'b000,
    PK_BUS_WIRING = 3'b001,
    PK_CODE       = 3'b010,
    PK_IRQ        = 3'b011,
    PK_SYS_STACK  = 3'b100,
    PK_USER_STACK = 3'b101
  } proc_kind_type;

  typedef enum logic [1:0] {
    LM_OFF   = 2'b00,
    LM_ON    = 2'b01,
    LM_BLINK = 2'b10
  } lamp_mode_type;

endpackage : fault_pkg

// ===== rtl/lamp_if.sv
/*
  Link between the fault manager core and one indicator lamp driver.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface lamp_if;
  fault_pkg::lamp_mode_type mode;
  logic                     lamp;
  modport ctl (output mode, input lamp);
  modport drv (input mode, output lamp);
endinterface : lamp_if

// ===== rtl/lamp_driver.sv
/*
  Drives one indicator lamp off, on or flashing from a mode request.
  Assumes every instance leaves reset together, so all lamps flash in step.
*/
`timescale 1ns/1ps
module lamp_driver #(
  parameter int unsigned HALF_CYCLES = 25000000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Lamp link
  lamp_if.drv      lnk
);
  localparam int CW = $clog2(HALF_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
    logic          lamp;
  } drv_type;

  drv_type s_r;
  drv_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt == CW'(HALF_CYCLES - 1)) begin
      s_nxt.cnt   = '0;
      s_nxt.phase = ~s_r.phase;
    end else begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
    unique case (lnk.mode)
      fault_pkg::LM_OFF:   s_nxt.lamp = 1'b0;
      fault_pkg::LM_ON:    s_nxt.lamp = 1'b1;
      fault_pkg::LM_BLINK: s_nxt.lamp = s_nxt.phase;
      default:             s_nxt.lamp = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.lamp = s_r.lamp;

endmodule : lamp_driver

// ===== rtl/pin_sync.sv
/*
  Two-stage synchroniser for an asynchronous pin with a rising-edge pulse.
  Assumes the pin stays high for at least two clock periods per press.
*/
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and pulse
  input wire logic pin,
  output logic     rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } sync_type;

  sync_type s_r;
  sync_type s_nxt;

  // The first stage feeds only the second; the edge looks at later stages.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.s1   = pin;
    s_nxt.s2   = s_r.s1;
    s_nxt.s3   = s_r.s2;
    s_nxt.rise = s_r.s2 & ~s_r.s3;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise = s_r.rise;

endmodule : pin_sync

// ===== rtl/fault_manager.sv
/*
  Controller fault manager: classifies execution, blocking and processor
  faults, keeps the fault flags and code words, runs the run/stop/halt/
  error state and drives the run and error lamps; APB register slave.
  Assumes fault events come as one-cycle pulses from logic on pclk and the
  reset pushbutton arrives asynchronously on a pin.
*/
// The implementer's own choices: the register offsets and register access over APB.
// How it works
// RULE1: an execution fault sets its sticky string, arithmetic or index flag.
// RULE2: software tests and clears those flags; hardware never clears them.
// RULE3: string error, overflow/float/divide, index overflow map to their flags.
// RULE4: with diagnostics on, selected execution faults halt and log a code.
// RULE5: a blocking fault halts all tasks at once without a processor fault.
// RULE6: only reinit command or the reset pushbutton leave the halt state; a processor fault in halt also moves it to error.
// RULE7: restart from halt initialises data, inputs and forces outputs to fallback.
// RULE8: after a halt restart the application runs only on a run command.
// RULE9: halt flashes both lamps and sets watchdog and/or chart flags.
// RULE10: chart table overrun and unresolved step set chart flag and own codes.
// RULE11: watchdog, halt instruction and unresolved jump each write their code.
// RULE12: escalated string, divide and overflow faults write their own codes.
// RULE13: escalated float error and index overflow write their own codes.
// RULE14: a processor fault stops in error; only a cold restart leaves it.
// RULE15: after a processor fault the next cold start comes up stopped.
// RULE16: processor fault causes are logged, bus faults with their two codes.
// RULE17: code, interrupt and stack faults are processor faults too.
// RULE18: in error every bus access is refused; the code reads after cold start.
// RULE19: a non-blocking fault leaves the operating state unchanged.
// RULE20: the first blocking fault code is kept until restart.
`timescale 1ns/1ps
`include "fault_consts.svh"
module fault_manager #(
  parameter int unsigned BLINK_HALF_CYCLES =
    `BLINK_HALF_MS * 1000 * `PCLK_MHZ
) (
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // APB slave
  input wire logic [11:0]               paddr,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [31:0]               pwdata,
  output logic     [31:0]               prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Fault events from the execution engine
  input wire logic                      exec_fault_valid,
  input wire fault_pkg::exec_kind_type  exec_fault_kind,
  input wire logic                      block_fault_valid,
  input wire fault_pkg::block_kind_type block_fault_kind,
  input wire logic                      proc_fault_valid,
  input wire fault_pkg::proc_kind_type  proc_fault_kind,
  // Reset pushbutton pin
  input wire logic                      reset_button,
  // Application control and lamps
  output logic                          app_run,
  output logic                          app_halt,
  output logic                          app_init,
  output logic                          outputs_fallback,
  output logic                          run_lamp,
  output logic                          err_lamp
);
  typedef struct packed {
    fault_pkg::state_type st;
    logic [4:0]           flags;
    logic [15:0]          bcode;
    logic [7:0]           pcode;
    logic                 forced_stop;
    logic [6:0]           ctrl;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 app_run;
    logic                 app_halt;
    logic                 app_init;
    logic                 fallback;
  } core_type;

  core_type s_r;
  core_type s_nxt;

  logic        btn_pulse;
  logic        setup;
  logic        access;
  logic        wr_ok;
  logic        wr_flags;
  logic        cmd_run;
  logic        cmd_stop;
  logic        cmd_reinit;
  logic        mapped;
  logic        escalate;
  logic        restart;
  logic [31:0] rd_mux;
  logic [15:0] esc_code;
  logic [15:0] blk_code;
  logic [7:0]  proc_code;
  logic [1:0]  blk_flags;

  lamp_if run_if ();
  lamp_if err_if ();

  pin_sync u_button (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (reset_button),
    .rise    (btn_pulse)
  );

  lamp_driver #(.HALF_CYCLES(BLINK_HALF_CYCLES)) u_run_lamp (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (run_if.drv)
  );

  lamp_driver #(.HALF_CYCLES(BLINK_HALF_CYCLES)) u_err_lamp (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (err_if.drv)
  );

  // Code lookups for each fault class.
  always_comb begin
    esc_code = `BC_STRING;
    unique case (exec_fault_kind)
      fault_pkg::EK_STRING: esc_code = `BC_STRING;  // RULE12
      fault_pkg::EK_DIV0:   esc_code = `BC_DIV0;    // RULE12
      fault_pkg::EK_CAPOV:  esc_code = `BC_CAPOV;   // RULE12
      fault_pkg::EK_FLOAT:  esc_code = `BC_FLOAT;   // RULE13
      fault_pkg::EK_INDEX:  esc_code = `BC_INDEX;   // RULE13
      default:              esc_code = `BC_STRING;
    endcase
    blk_flags = 2'b00;
    unique case (block_fault_kind)
      fault_pkg::BK_WATCHDOG: begin
        blk_code  = `BC_WATCHDOG;                   // RULE11
        blk_flags = 2'b01;
      end
      fault_pkg::BK_CHART_TABLE: begin
        blk_code  = `BC_CHART_TABLE;                // RULE10
        blk_flags = 2'b10;
      end
      fault_pkg::BK_CHART_STEP: begin
        blk_code  = `BC_CHART_STEP;                 // RULE10
        blk_flags = 2'b10;
      end
      fault_pkg::BK_HALT_INSTR: blk_code = `BC_HALT_INSTR; // RULE11
      fault_pkg::BK_JUMP:       blk_code = `BC_JUMP;       // RULE11
      default:                  blk_code = `BC_WATCHDOG;
    endcase
    unique case (proc_fault_kind)
      fault_pkg::PK_SYS_WD_BUS: proc_code = `PC_SYS_WD_BUS; // RULE16
      fault_pkg::PK_BUS_WIRING: proc_code = `PC_BUS_WIRING; // RULE16
      fault_pkg::PK_CODE:       proc_code = `PC_CODE;       // RULE17
      fault_pkg::PK_IRQ:        proc_code = `PC_IRQ;        // RULE17
      fault_pkg::PK_SYS_STACK:  proc_code = `PC_SYS_STACK;  // RULE17
      fault_pkg::PK_USER_STACK: proc_code = `PC_USER_STACK; // RULE17
      default:                  proc_code = `PC_CODE;
    endcase
  end

  // Bus decode and read mux.
  always_comb begin
    setup    = psel && !penable;
    access   = psel && penable && s_r.pready;
    wr_ok    = access && pwrite && !s_r.pslverr;
    wr_flags = wr_ok && (paddr == `OFS_FLAGS);
    cmd_run    = wr_ok && (paddr == `OFS_CMD) && pwdata[`CMD_RUN];
    cmd_stop   = wr_ok && (paddr == `OFS_CMD) && pwdata[`CMD_STOP];
    cmd_reinit = wr_ok && (paddr == `OFS_CMD) && pwdata[`CMD_REINIT];
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      `OFS_STATUS: rd_mux = {23'h000000, s_r.flags, s_r.forced_stop,
                             s_r.st};
      `OFS_FLAGS:  rd_mux = {27'h0000000, s_r.flags};
      `OFS_BCODE:  rd_mux = {16'h0000, s_r.bcode};
      `OFS_PCODE:  rd_mux = {24'h000000, s_r.pcode};
      `OFS_CTRL:   rd_mux = {25'h0000000, s_r.ctrl};
      `OFS_CMD:    rd_mux = 32'h00000000;
      default:     mapped = 1'b0;
    endcase
    escalate = s_r.ctrl[`CTL_DIAG] &&
               s_r.ctrl[`CTL_ESC_LSB + 32'(exec_fault_kind)];
    restart  = btn_pulse || cmd_reinit;
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.app_init = 1'b0;
    // Registers answer from the setup cycle, so pready is high in the
    // first access cycle and no wait states are ever inserted.
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.pslverr = !mapped || (s_r.st == fault_pkg::ST_ERROR); // RULE18
      s_nxt.prdata  = (s_r.st == fault_pkg::ST_ERROR) ? 32'h00000000
                                                      : rd_mux;
    end else begin
      s_nxt.pslverr = 1'b0;
    end
    if (wr_ok && paddr == `OFS_CTRL) begin
      s_nxt.ctrl = pwdata[6:0];
    end
    // Software may only clear the three execution flags.
    if (wr_flags) begin
      s_nxt.flags[2:0] = s_r.flags[2:0] & pwdata[2:0]; // RULE2
    end
    if (s_r.st == fault_pkg::ST_RUNNING && exec_fault_valid) begin
      unique case (exec_fault_kind)
        fault_pkg::EK_STRING: s_nxt.flags[`FLG_STRING] = 1'b1; // RULE3
        fault_pkg::EK_INDEX:  s_nxt.flags[`FLG_INDEX]  = 1'b1; // RULE3
        default:              s_nxt.flags[`FLG_ARITH]  = 1'b1; // RULE1
      endcase
    end
    unique case (s_r.st)
      fault_pkg::ST_STOPPED, fault_pkg::ST_RUNNING: begin
        if (restart) begin
          s_nxt.st = (btn_pulse && s_r.ctrl[`CTL_AUTORUN])
                     ? fault_pkg::ST_RUNNING : fault_pkg::ST_STOPPED;
          s_nxt.app_init = 1'b1;
        end else if (cmd_stop) begin
          s_nxt.st = fault_pkg::ST_STOPPED;
        end else if (cmd_run) begin
          s_nxt.st          = fault_pkg::ST_RUNNING;
          s_nxt.forced_stop = 1'b0;
        end
        // Execution faults only block when escalated; otherwise the
        // state is left alone.
        if (s_r.st == fault_pkg::ST_RUNNING) begin          // RULE20
          if (block_fault_valid) begin
            s_nxt.st = fault_pkg::ST_HALT;                  // RULE5
            s_nxt.bcode = blk_code;                         // RULE11
            s_nxt.flags[`FLG_CHART:`FLG_WDOG] = blk_flags;  // RULE9
          end else if (exec_fault_valid && escalate) begin  // RULE19
            s_nxt.st    = fault_pkg::ST_HALT;               // RULE4
            s_nxt.bcode = esc_code;                         // RULE4
          end
        end
      end
      fault_pkg::ST_HALT: begin
        // Later blocking faults are ignored so the first code survives.
        if (restart) begin                                  // RULE6
          s_nxt.st       = fault_pkg::ST_STOPPED;           // RULE8
          s_nxt.app_init = 1'b1;                            // RULE7
          s_nxt.bcode    = 16'h0000;
          s_nxt.flags[`FLG_CHART:`FLG_WDOG] = 2'b00;
        end
      end
      fault_pkg::ST_ERROR: begin
        if (btn_pulse) begin                                // RULE14
          s_nxt.st       = fault_pkg::ST_STOPPED;           // RULE15
          s_nxt.app_init = 1'b1;
        end
      end
      default: s_nxt.st = fault_pkg::ST_ERROR;
    endcase
    // Outside the error state, a processor fault outranks any other state change in its cycle and clears app_init.
    if (proc_fault_valid && s_r.st != fault_pkg::ST_ERROR) begin
      s_nxt.st          = fault_pkg::ST_ERROR;              // RULE14
      s_nxt.pcode       = proc_code;                        // RULE16
      s_nxt.forced_stop = 1'b1;                             // RULE15
      s_nxt.app_init    = 1'b0;
    end
    s_nxt.app_run  = (s_nxt.st == fault_pkg::ST_RUNNING);
    s_nxt.app_halt = (s_nxt.st == fault_pkg::ST_HALT);      // RULE5
    s_nxt.fallback = (s_nxt.st != fault_pkg::ST_RUNNING);   // RULE7
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r       <= '0;
      s_r.ctrl  <= `CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Lamp modes follow the registered state.
  always_comb begin
    unique case (s_r.st)
      fault_pkg::ST_RUNNING: begin
        run_if.mode = fault_pkg::LM_ON;
        err_if.mode = fault_pkg::LM_OFF;
      end
      fault_pkg::ST_HALT: begin
        run_if.mode = fault_pkg::LM_BLINK;                  // RULE9
        err_if.mode = fault_pkg::LM_BLINK;                  // RULE9
      end
      fault_pkg::ST_ERROR: begin
        run_if.mode = fault_pkg::LM_OFF;
        err_if.mode = fault_pkg::LM_ON;
      end
      default: begin
        run_if.mode = fault_pkg::LM_BLINK;
        err_if.mode = fault_pkg::LM_OFF;
      end
    endcase
  end

  assign prdata           = s_r.prdata;
  assign pready           = s_r.pready;
  assign pslverr          = s_r.pslverr;
  assign app_run          = s_r.app_run;
  assign app_halt         = s_r.app_halt;
  assign app_init         = s_r.app_init;
  assign outputs_fallback = s_r.fallback;
  assign run_lamp         = run_if.lamp;
  assign err_lamp         = err_if.lamp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_halt_restart;
    s_r.st == fault_pkg::ST_HALT && restart && !proc_fault_valid;
  endsequence

  sequence seq_init_then_idle;
    app_init && s_r.st == fault_pkg::ST_STOPPED ##1 !app_init;
  endsequence

  chk_string_flag_set: assert property ( // RULE1
    (s_r.st == fault_pkg::ST_RUNNING && exec_fault_valid &&
     exec_fault_kind == fault_pkg::EK_STRING) |=> s_r.flags[`FLG_STRING])
    else $error("string fault did not set its flag");

  chk_flag_only_sw: assert property ( // RULE2
    $fell(s_r.flags[`FLG_INDEX]) |-> $past(wr_flags && !pwdata[2]))
    else $error("index flag cleared without a software write");

  chk_halt_entry: assert property ( // RULE5
    (s_r.st == fault_pkg::ST_RUNNING && block_fault_valid &&
     !proc_fault_valid) |=> app_halt && !app_run && outputs_fallback)
    else $error("blocking fault did not halt the application");

  chk_watchdog_code: assert property ( // RULE11
    (s_r.st == fault_pkg::ST_RUNNING && block_fault_valid &&
     block_fault_kind == fault_pkg::BK_WATCHDOG && !proc_fault_valid)
    |=> s_r.bcode == 16'hDEB0 && s_r.flags[`FLG_WDOG])
    else $error("watchdog code or flag wrong");

  chk_escalate_div: assert property ( // RULE4
    (s_r.st == fault_pkg::ST_RUNNING && exec_fault_valid && escalate &&
     !block_fault_valid && !proc_fault_valid &&
     exec_fault_kind == fault_pkg::EK_DIV0)
    |=> s_r.st == fault_pkg::ST_HALT && s_r.bcode == 16'hDEF0)
    else $error("escalated divide fault not recorded");

  chk_first_code_kept: assert property ( // RULE20
    (s_r.st == fault_pkg::ST_HALT && !restart && !proc_fault_valid)
    |=> $stable(s_r.bcode))
    else $error("blocking code changed during halt");

  chk_halt_restart: assert property ( // RULE8
    seq_halt_restart |=> seq_init_then_idle)
    else $error("halt restart did not initialise into stop");

  chk_error_sticky: assert property ( // RULE14
    (s_r.st == fault_pkg::ST_ERROR && !btn_pulse)
    |=> s_r.st == fault_pkg::ST_ERROR)
    else $error("error state left without a cold restart");

  chk_forced_stop: assert property ( // RULE15
    (s_r.st == fault_pkg::ST_ERROR && btn_pulse)
    |=> s_r.st == fault_pkg::ST_STOPPED && s_r.forced_stop)
    else $error("cold start after processor fault not stopped");

  chk_bus_refused: assert property ( // RULE18
    (s_r.st == fault_pkg::ST_ERROR && setup) |=> pslverr && pready)
    else $error("bus access accepted in error state");

  chk_halt_lamps: assert property ( // RULE9
    s_r.st == fault_pkg::ST_HALT |-> run_if.mode == fault_pkg::LM_BLINK
                                   && err_if.mode == fault_pkg::LM_BLINK)
    else $error("halt lamps not both flashing");

  chk_nonblock_state: assert property ( // RULE19
    (s_r.st == fault_pkg::ST_RUNNING && exec_fault_valid && !escalate &&
     !block_fault_valid && !proc_fault_valid && !restart && !cmd_stop)
    |=> s_r.st == fault_pkg::ST_RUNNING)
    else $error("non-blocking fault changed the state");

endmodule : fault_manager

// ===== tb/app_partner.sv
/*
  Model of the application engine and operator: fault event pulses and
  the processor reset pushbutton.
  Assumes it is driven from the bench on the rising edge of pclk.
*/
`timescale 1ns/1ps
module app_partner (
  // Clock
  input wire logic                 pclk,
  // Fault events
  output logic                     exec_fault_valid,
  output fault_pkg::exec_kind_type exec_fault_kind,
  output logic                     block_fault_valid,
  output fault_pkg::block_kind_type block_fault_kind,
  output logic                     proc_fault_valid,
  output fault_pkg::proc_kind_type proc_fault_kind,
  // Pushbutton pin
  output logic                     reset_button
);
  initial begin
    exec_fault_valid = 1'b0;
    exec_fault_kind = fault_pkg::EK_STRING;
    block_fault_valid = 1'b0;
    block_fault_kind = fault_pkg::BK_WATCHDOG;
    proc_fault_valid = 1'b0;
    proc_fault_kind = fault_pkg::PK_CODE;
    reset_button = 1'b0;
  end
  task exec_ev(input int k);
    @(posedge pclk);
    exec_fault_valid <= 1'b1;
    exec_fault_kind <= fault_pkg::exec_kind_type'(k);
    @(posedge pclk);
    exec_fault_valid <= 1'b0;
  endtask : exec_ev
  task block_ev(input int k);
    @(posedge pclk);
    block_fault_valid <= 1'b1;
    block_fault_kind <= fault_pkg::block_kind_type'(k);
    @(posedge pclk);
    block_fault_valid <= 1'b0;
  endtask : block_ev
  task proc_ev(input int k);
    @(posedge pclk);
    proc_fault_valid <= 1'b1;
    proc_fault_kind <= fault_pkg::proc_kind_type'(k);
    @(posedge pclk);
    proc_fault_valid <= 1'b0;
  endtask : proc_ev
  // The pin is held four cycles so the synchroniser sees one clean press.
  task press;
    @(posedge pclk);
    reset_button <= 1'b1;
    repeat (4) @(posedge pclk);
    reset_button <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : press
endmodule : app_partner

// ===== tb/fault_manager_tb.sv
/*
  Self-checking bench of the fault manager: APB master, partner model.
  Assumes the lamp half period parameter is shortened to 4 cycles.
*/
`timescale 1ns/1ps
`include "fault_consts.svh"
module fault_manager_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, e, app_run, app_halt, app_init;
  logic outputs_fallback, run_lamp, err_lamp, reset_button;
  logic exec_fault_valid, block_fault_valid, proc_fault_valid;
  fault_pkg::exec_kind_type exec_fault_kind;
  fault_pkg::block_kind_type block_fault_kind;
  fault_pkg::proc_kind_type proc_fault_kind;
  int miscompares = 0, checks_done = 0, cycles = 0, inits = 0, n0;
  logic [1:0] lp;
  app_partner i_app_partner (.pclk(pclk), .exec_fault_valid(exec_fault_valid),
    .exec_fault_kind(exec_fault_kind), .block_fault_valid(block_fault_valid),
    .block_fault_kind(block_fault_kind), .proc_fault_valid(proc_fault_valid),
    .proc_fault_kind(proc_fault_kind), .reset_button(reset_button));
  fault_manager #(.BLINK_HALF_CYCLES(4)) i_fault_manager (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec_fault_valid(exec_fault_valid),
    .exec_fault_kind(exec_fault_kind), .block_fault_valid(block_fault_valid),
    .block_fault_kind(block_fault_kind), .proc_fault_valid(proc_fault_valid),
    .proc_fault_kind(proc_fault_kind), .reset_button(reset_button),
    .app_run(app_run), .app_halt(app_halt), .app_init(app_init),
    .outputs_fallback(outputs_fallback), .run_lamp(run_lamp),
    .err_lamp(err_lamp));
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (app_init === 1'b1) inits <= inits + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task check(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  // Request is held until pready is seen high; only then is it released.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(nm, q, x);
  endtask : rd
  task t_reset;
    rd("status", `OFS_STATUS, 32'h0);
    rd("ctrl", `OFS_CTRL, 32'h0);
    rd("unmapped", 12'h018, 32'h0);
    check("unmapped err", e, 32'h1);
  endtask : t_reset
  task t_exec;
    logic [2:0] fb [5] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h4};
    apb(1'b1, `OFS_CMD, 32'h1);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `OFS_FLAGS, 32'h0);
      i_app_partner.exec_ev(k);
      rd("exec flag", `OFS_FLAGS, {29'h0, fb[k]});
      rd("exec state", `OFS_STATUS, {23'h0, 2'h0, fb[k], 1'b0, 3'h1});
    end
    apb(1'b1, `OFS_FLAGS, 32'h0);
    apb(1'b1, `OFS_CMD, 32'h2);
    rd("stop cmd", `OFS_STATUS, 32'h0);
  endtask : t_exec
  task t_block;
    logic [15:0] bc [5] = '{16'hDEB0, 16'hDEF7, 16'hDEFE, 16'h2258, 16'hDEF8};
    logic [1:0] bf [5] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `OFS_CMD, 32'h1);
      i_app_partner.block_ev(k);
      i_app_partner.block_ev((k + 1) % 5);
      check("halt", {app_halt, app_run, outputs_fallback}, 32'h5);
      rd("bcode", `OFS_BCODE, {16'h0, bc[k]});
      rd("bflags", `OFS_FLAGS, {27'h0, bf[k], 3'h0});
      lp = {run_lamp, err_lamp};
      check("lamp phase", run_lamp, err_lamp);
      repeat (4) @(posedge pclk);
      check("lamp flash", lp ^ {run_lamp, err_lamp}, 32'h3);
      n0 = inits;
      if (k % 2) i_app_partner.press;
      else apb(1'b1, `OFS_CMD, 32'h4);
      repeat (2) @(posedge pclk);
      check("init", inits - n0, 32'h1);
      rd("restart", `OFS_STATUS, 32'h0);
      rd("code clr", `OFS_BCODE, 32'h0);
      check("no run", {app_run, outputs_fallback}, 32'h1);
    end
  endtask : t_block
  task t_esc;
    logic [15:0] ec [5] = '{16'hDEF1, 16'hDEF0, 16'hDEF2, 16'hDE87, 16'hDEF3};
    apb(1'b1, `OFS_CTRL, 32'h7D);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `OFS_CMD, 32'h1);
      i_app_partner.exec_ev(k);
      @(posedge pclk);
      check("esc halt", app_halt, 32'h1);
      rd("esc code", `OFS_BCODE, {16'h0, ec[k]});
      apb(1'b1, `OFS_CMD, 32'h4);
      apb(1'b1, `OFS_FLAGS, 32'h0);
    end
  endtask : t_esc
  task t_proc;
    logic [7:0] pc [6] = '{8'h80, 8'h81, 8'h01, 8'h02, 8'h03, 8'h04};
    apb(1'b1, `OFS_CTRL, 32'h2);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, `OFS_CMD, 32'h1);
      i_app_partner.proc_ev(k);
      i_app_partner.block_ev(0);
      rd("err read", `OFS_STATUS, 32'h0);
      check("err refused", e, 32'h1);
      apb(1'b1, `OFS_CMD, 32'h4);
      check("err lamps", {app_run, run_lamp, err_lamp}, 32'h1);
      i_app_partner.press;
      rd("forced stop", `OFS_STATUS, 32'h8);
      rd("pcode", `OFS_PCODE, {24'h0, pc[k]});
    end
    i_app_partner.press;
    rd("autorun", `OFS_STATUS, 32'h9);
  endtask : t_proc
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_exec;
    t_block;
    t_esc;
    t_proc;
    final_report;
  end
endmodule : fault_manager_tb
